/* design/obc_defs.svh */
// Constants for the option-board controller: offsets, fields, resets, timing
`ifndef OBC_DEFS_SVH
`define OBC_DEFS_SVH

// ==================================================
// Clock and tick
`define OBC_CLK_MHZ        250
`define OBC_TICK_MS        100
`define OBC_TICK_CYCLES    (`OBC_TICK_MS * 1000 * `OBC_CLK_MHZ)
`define OBC_SEC_TICKS      (1000 / `OBC_TICK_MS)

// ==================================================
// Delay units in seconds, then in ticks
`define OBC_UNIT_START_S   1
`define OBC_UNIT_XFER_S    1
`define OBC_UNIT_RETR_S    180
`define OBC_UNIT_COOL_S    60
`define OBC_UNIT_EXER_S    300
`define OBC_LOADCTL_LO_S   300
`define OBC_LOADCTL_HI_S   600
`define OBC_TICKS(s)       (16'((s) * `OBC_SEC_TICKS))

// ==================================================
// Highest selector position, and positions when no board is used
`define OBC_POS_MAX        4'ha
`define OBC_FAC_START      4'h3
`define OBC_FAC_XFER       4'h3
`define OBC_FAC_RETR       4'h5
`define OBC_FAC_COOL       4'h5
`define OBC_FAC_EXER       4'h4

// ==================================================
// Panel timing in seconds, then in ticks and counts
`define OBC_HOLD_S         1
`define OBC_START_FAIL_S   120
`define OBC_CHIRP_PER_S    600
`define OBC_LAMP_S         2
`define OBC_SLOW_HALF      5'h0a
`define OBC_FAST_HALF      5'h05
`define OBC_BLINK_PER      5'h14
`define OBC_BEEPS_ONE      4'h4
`define OBC_BEEPS_THREE    4'hc
`define OBC_DB_TICKS       2'h3

// ==================================================
// Register map
`define OBC_REG_CTRL       12'h000
`define OBC_REG_STATUS     12'h004
`define OBC_CTRL_RESET     32'h0000_0003
`define OBC_CTRL_BOARD     0
`define OBC_CTRL_RTEST     1
`define OBC_ST_STATE_LO    0
`define OBC_ST_SILENCED    2
`define OBC_ST_STARTFAIL   3
`define OBC_ST_TWOWEEK     4
`define OBC_ST_LOADED      5
`define OBC_ST_TESTRUN     6

`endif

/* design/obc_pkg.sv */
// Types shared by the option-board controller
package obc_pkg;
  // Remote test sequence
  typedef enum logic [1:0] {
    OBC_IDLE,
    OBC_STARTING,
    OBC_RUNNING,
    OBC_STOPPING
  } obc_test_t;
endpackage : obc_pkg

/* design/obc_debounce.sv */
// Synchroniser and tick-based debouncer for switch and button inputs
`timescale 1ns/1ps
`include "obc_defs.svh"

module obc_debounce #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] sync1_ff;
  logic [W-1:0] sync2_ff;

  // ==================================================
  // Two-stage synchroniser
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= din;
      sync2_ff <= sync1_ff;
    end
  end

  // ==================================================
  // Per-bit stability counter on the tick
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [1:0] cnt_ff;
    logic       out_ff;
    always_ff @(posedge mclk) begin
      if (rst) begin
        cnt_ff <= 2'h0;
        out_ff <= 1'b0;
      end else if (tick) begin
        if (sync2_ff[i] == out_ff) begin
          cnt_ff <= 2'h0;
        end else if (cnt_ff == `OBC_DB_TICKS) begin
          out_ff <= sync2_ff[i];
          cnt_ff <= 2'h0;
        end else begin
          cnt_ff <= cnt_ff + 2'h1;
        end
      end
    end
    assign dout[i] = out_ff;
  end

endmodule : obc_debounce

/* design/obc_ctrl.sv */
// Option-board controller: delay selectors, mode switches, remote panel logic
`timescale 1ns/1ps
`include "obc_defs.svh"

module obc_ctrl #(
  parameter int TICK_CYCLES = `OBC_TICK_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Board switches
  input  wire logic [3:0]  sel_cooldown,
  input  wire logic [3:0]  sel_start,
  input  wire logic [3:0]  sel_xfer,
  input  wire logic [3:0]  sel_retransfer,
  input  wire logic [3:0]  sel_exercise,
  input  wire logic [4:0]  cfg_sw,
  // Remote alarm panel buttons
  input  wire logic        remote_test_in,
  input  wire logic        silence_btn,
  // Controller status
  input  wire logic        utility_avail,
  input  wire logic        gen_running,
  input  wire logic        load_on_gen,
  input  wire logic        silent_mode,
  input  wire logic        system_fault,
  input  wire logic        panel_batt_low,
  input  wire logic        exercise_done,
  // Delay and mode outputs, in ticks
  output logic      [15:0] dly_engine_start,
  output logic      [15:0] dly_xfer_to_emerg,
  output logic      [15:0] dly_retransfer,
  output logic      [15:0] dly_cooldown,
  output logic      [15:0] dly_exercise_run,
  output logic      [15:0] dly_load_control,
  output logic             exercise_two_week,
  output logic             exercise_loaded,
  output logic             test_run,
  output logic             test_transfer,
  // Remote alarm panel and local horn
  output logic             generator_supply_indicator,
  output logic             fault_indicator,
  output logic             remote_horn,
  output logic             local_horn,
  output logic             alarm_silenced
);

  localparam logic [15:0] HOLD_T  = `OBC_TICKS(`OBC_HOLD_S);
  localparam logic [15:0] FAIL_T  = `OBC_TICKS(`OBC_START_FAIL_S);
  localparam logic [15:0] CHIRP_T = `OBC_TICKS(`OBC_CHIRP_PER_S);
  localparam logic [15:0] LAMP_T  = `OBC_TICKS(`OBC_LAMP_S);

  logic [31:0]          div_ff;
  logic                 tick;
  logic [27:0]          sw_db;
  logic [31:0]          ctrl_ff;
  logic [31:0]          prdata_ff;
  obc_pkg::obc_test_t   state_ff;
  obc_pkg::obc_test_t   nxt_state;
  logic                 test_db_q_ff;
  logic                 sil_db_q_ff;
  logic [15:0]          hold_ff;
  logic                 ev_start;
  logic                 ev_stop;
  logic [15:0]          fail_cnt_ff;
  logic                 start_fail_ff;
  logic                 first_ex_ff;
  logic                 two_week_ff;
  logic                 silenced_ff;
  logic [15:0]          lamp_ff;
  logic [4:0]           blink_ff;
  logic [15:0]          chirp_cnt_ff;
  logic [3:0]           beep_ff;
  logic                 fault_on;
  logic                 remote_chirp;
  logic                 board_use;
  logic                 test_db;
  logic                 sil_db;
  logic                 apb_hit;

  // Scale a selector position by its unit
  function automatic logic [15:0] obc_scale(input logic [3:0] pos, input logic [15:0] unit);
    logic [3:0] p;
    p = (pos == 4'h0 || pos > `OBC_POS_MAX) ? `OBC_POS_MAX : pos;
    obc_scale = 16'({12'h000, p} * unit);
  endfunction : obc_scale

  // ==================================================
  // System tick divider
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_ff <= 32'h0;
    end else if (div_ff >= 32'(TICK_CYCLES - 1)) begin
      div_ff <= 32'h0;
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end
  assign tick = (div_ff >= 32'(TICK_CYCLES - 1));

  // ==================================================
  // Input conditioning
  obc_debounce #(.W(28)) u_db (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick),
    .din  ({silence_btn, remote_test_in, sel_cooldown, sel_start, sel_xfer,
            sel_retransfer, sel_exercise, cfg_sw, 1'b0}),
    .dout (sw_db)
  );
  assign sil_db    = sw_db[27];
  assign test_db   = sw_db[26] & ctrl_ff[`OBC_CTRL_RTEST];
  assign board_use = ctrl_ff[`OBC_CTRL_BOARD];

  // ==================================================
  // APB slave, zero wait states
  assign apb_hit = (paddr == `OBC_REG_CTRL) || (paddr == `OBC_REG_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;
  assign prdata  = prdata_ff;

  // Control register write
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= `OBC_CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == `OBC_REG_CTRL) begin
      ctrl_ff <= {30'h0, pwdata[1:0]};
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OBC_REG_CTRL:   prdata_ff <= ctrl_ff;
        `OBC_REG_STATUS: prdata_ff <= {25'h0, test_run, exercise_loaded, two_week_ff,
                                       start_fail_ff, silenced_ff, state_ff};
        default:         prdata_ff <= 32'h0;
      endcase
    end
  end

  // ==================================================
  // Delay values from selectors or factory positions
  always_ff @(posedge mclk) begin
    if (rst) begin
      dly_engine_start  <= 16'h0;
      dly_xfer_to_emerg <= 16'h0;
      dly_retransfer    <= 16'h0;
      dly_cooldown      <= 16'h0;
      dly_exercise_run  <= 16'h0;
      dly_load_control  <= 16'h0;
    end else begin
      dly_engine_start  <= obc_scale(board_use ? sw_db[21:18] : `OBC_FAC_START,
                                     `OBC_TICKS(`OBC_UNIT_START_S));
      dly_xfer_to_emerg <= obc_scale(board_use ? sw_db[17:14] : `OBC_FAC_XFER,
                                     `OBC_TICKS(`OBC_UNIT_XFER_S));
      dly_retransfer    <= obc_scale(board_use ? sw_db[13:10] : `OBC_FAC_RETR,
                                     `OBC_TICKS(`OBC_UNIT_RETR_S));
      dly_cooldown      <= obc_scale(board_use ? sw_db[25:22] : `OBC_FAC_COOL,
                                     `OBC_TICKS(`OBC_UNIT_COOL_S));
      dly_exercise_run  <= obc_scale(board_use ? sw_db[9:6] : `OBC_FAC_EXER,
                                     `OBC_TICKS(`OBC_UNIT_EXER_S));
      dly_load_control  <= (board_use && sw_db[4]) ? `OBC_TICKS(`OBC_LOADCTL_HI_S)
                                                   : `OBC_TICKS(`OBC_LOADCTL_LO_S);
    end
  end

  // ==================================================
  // Exercise interval and loading
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_ex_ff <= 1'b1;
      two_week_ff <= 1'b0;
    end else begin
      if (exercise_done) begin
        first_ex_ff <= 1'b0;
      end
      if (exercise_done || first_ex_ff) begin
        two_week_ff <= board_use & sw_db[1];
      end
    end
  end
  assign exercise_two_week = two_week_ff;
  assign exercise_loaded   = board_use & sw_db[2] & ~first_ex_ff;

  // ==================================================
  // Test button edges and hold time
  always_ff @(posedge mclk) begin
    if (rst) begin
      test_db_q_ff <= 1'b0;
      sil_db_q_ff  <= 1'b0;
      hold_ff      <= 16'h0;
    end else begin
      test_db_q_ff <= test_db;
      sil_db_q_ff  <= sil_db;
      if (!test_db) begin
        hold_ff <= 16'h0;
      end else if (tick && hold_ff < HOLD_T) begin
        hold_ff <= hold_ff + 16'h1;
      end
    end
  end

  // Start and stop events per test mode
  always_comb begin
    ev_start = 1'b0;
    ev_stop  = 1'b0;
    if (sw_db[3]) begin
      ev_start = test_db & ~test_db_q_ff;
      ev_stop  = ~test_db & test_db_q_ff;
    end else if (!test_db && test_db_q_ff && hold_ff >= HOLD_T) begin
      ev_start = 1'b1;
      ev_stop  = 1'b1;
    end
  end

  // ==================================================
  // Remote test sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      obc_pkg::OBC_IDLE: begin
        if (ev_start) begin
          nxt_state = obc_pkg::OBC_STARTING;
        end
      end
      obc_pkg::OBC_STARTING: begin
        if (ev_stop && utility_avail) begin
          nxt_state = obc_pkg::OBC_STOPPING;
        end else if (gen_running && load_on_gen) begin
          nxt_state = obc_pkg::OBC_RUNNING;
        end
      end
      obc_pkg::OBC_RUNNING: begin
        if (ev_stop && utility_avail) begin
          nxt_state = obc_pkg::OBC_STOPPING;
        end
      end
      obc_pkg::OBC_STOPPING: begin
        if (!gen_running) begin
          nxt_state = obc_pkg::OBC_IDLE;
        end
      end
      default: nxt_state = obc_pkg::OBC_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= obc_pkg::OBC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign test_run      = (state_ff == obc_pkg::OBC_STARTING) ||
                         (state_ff == obc_pkg::OBC_RUNNING);
  assign test_transfer = test_run;

  // ==================================================
  // Start timeout watch
  always_ff @(posedge mclk) begin
    if (rst) begin
      fail_cnt_ff   <= 16'h0;
      start_fail_ff <= 1'b0;
    end else if (state_ff != obc_pkg::OBC_STARTING) begin
      fail_cnt_ff   <= 16'h0;
      start_fail_ff <= 1'b0;
    end else if (tick) begin
      if (fail_cnt_ff >= FAIL_T - 16'h1) begin
        start_fail_ff <= 1'b1;
      end else begin
        fail_cnt_ff <= fail_cnt_ff + 16'h1;
      end
    end
  end

  // ==================================================
  // Silence toggle and lamp test
  always_ff @(posedge mclk) begin
    if (rst) begin
      silenced_ff <= 1'b0;
      lamp_ff     <= 16'h0;
    end else if (sil_db && !sil_db_q_ff) begin
      silenced_ff <= ~silenced_ff;
      lamp_ff     <= LAMP_T;
    end else if (tick && lamp_ff != 16'h0) begin
      lamp_ff <= lamp_ff - 16'h1;
    end
  end
  assign alarm_silenced = silenced_ff;

  // ==================================================
  // Flash phase counter
  always_ff @(posedge mclk) begin
    if (rst) begin
      blink_ff <= 5'h0;
    end else if (tick) begin
      blink_ff <= (blink_ff >= `OBC_BLINK_PER - 5'h1) ? 5'h0 : blink_ff + 5'h1;
    end
  end

  // Indicator drive with lamp test override
  always_comb begin
    if (lamp_ff != 16'h0) begin
      generator_supply_indicator = 1'b1;
    end else if (state_ff == obc_pkg::OBC_STARTING || state_ff == obc_pkg::OBC_STOPPING) begin
      generator_supply_indicator = blink_ff < `OBC_SLOW_HALF;
    end else if (load_on_gen && silent_mode) begin
      generator_supply_indicator = (blink_ff < `OBC_FAST_HALF) ||
                                   (blink_ff >= `OBC_SLOW_HALF &&
                                    blink_ff < `OBC_SLOW_HALF + `OBC_FAST_HALF);
    end else begin
      generator_supply_indicator = load_on_gen & gen_running;
    end
  end

  assign fault_on = system_fault | panel_batt_low;
  always_comb begin
    if (lamp_ff != 16'h0 || fault_on) begin
      fault_indicator = 1'b1;
    end else begin
      fault_indicator = start_fail_ff & (blink_ff < `OBC_SLOW_HALF);
    end
  end

  // ==================================================
  // Chirp period and beep sequencer
  assign remote_chirp = (state_ff == obc_pkg::OBC_RUNNING) && gen_running;
  always_ff @(posedge mclk) begin
    if (rst) begin
      chirp_cnt_ff <= 16'h0;
      beep_ff      <= 4'h0;
    end else if (!fault_on && !remote_chirp) begin
      chirp_cnt_ff <= 16'h0;
      beep_ff      <= 4'h0;
    end else if (tick) begin
      if (chirp_cnt_ff == 16'h0) begin
        beep_ff <= fault_on ? `OBC_BEEPS_THREE : `OBC_BEEPS_ONE;
      end else if (beep_ff != 4'h0) begin
        beep_ff <= beep_ff - 4'h1;
      end
      chirp_cnt_ff <= (chirp_cnt_ff >= CHIRP_T - 16'h1) ? 16'h0 : chirp_cnt_ff + 16'h1;
    end
  end
  assign remote_horn = beep_ff[1] & ~silenced_ff;
  assign local_horn  = fault_on & board_use & sw_db[5] & ~silenced_ff;

endmodule : obc_ctrl

/* verification/obc_ctrl_chk.sv */
// Port checker for the option-board controller
`timescale 1ns/1ps
module obc_ctrl_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] dly_engine_start,
  input wire logic [15:0] dly_retransfer,
  input wire logic [15:0] dly_cooldown,
  input wire logic [15:0] dly_exercise_run,
  input wire logic [15:0] dly_load_control,
  input wire logic        test_run,
  input wire logic        test_transfer,
  input wire logic        utility_avail,
  input wire logic        system_fault,
  input wire logic        generator_supply_indicator,
  input wire logic        fault_indicator,
  input wire logic        remote_horn,
  input wire logic        local_horn,
  input wire logic        alarm_silenced
);
  // ==========================================
  // Clocking and sequences
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Lamp test keeps both indicators lit
  sequence lamp_s;
    (generator_supply_indicator && fault_indicator) [*8];
  endsequence

  // ==========================================
  // Bus and delay outputs
  pready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  bad_addr_a: assert property (psel && penable && paddr != 12'h000 && paddr != 12'h004 |-> pslverr)
    else $error("unmapped access without error");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  start_dly_a: assert property (!$past(rst) |-> dly_engine_start inside {[16'h000a:16'h0064]} && dly_engine_start % 16'h000a == 16'h0000)
    else $error("start delay off grid");
  retr_dly_a: assert property (!$past(rst) |-> dly_retransfer inside {[16'h0708:16'h4650]} && dly_retransfer % 16'h0708 == 16'h0000)
    else $error("retransfer delay off grid");
  cool_exer_a: assert property (!$past(rst) |-> dly_cooldown % 16'h0258 == 16'h0000 && dly_exercise_run % 16'h0bb8 == 16'h0000)
    else $error("cooldown or exercise off grid");
  load_ctl_a: assert property (!$past(rst) |-> dly_load_control inside {16'h0bb8, 16'h1770})
    else $error("load control not 5 or 10 min");

  // ==========================================
  // Test and panel outputs
  xfer_run_a: assert property (test_transfer == test_run)
    else $error("transfer not with test run");
  stop_util_a: assert property ($fell(test_run) |-> $past(utility_avail))
    else $error("test stopped without utility");
  fault_on_a: assert property (system_fault [*4] |=> fault_indicator)
    else $error("fault indicator not steady");
  mute_a: assert property (alarm_silenced [*2] |-> !remote_horn && !local_horn)
    else $error("horn sounds while silenced");
  lamp_test_a: assert property ($changed(alarm_silenced) |-> ##[0:2] lamp_s)
    else $error("no lamp test on silence");
endmodule : obc_ctrl_chk

bind obc_ctrl obc_ctrl_chk u_obc_ctrl_chk (.mclk, .rst, .psel, .penable,
  .paddr, .pready, .pslverr, .dly_engine_start,
  .dly_retransfer, .dly_cooldown, .dly_exercise_run,
  .dly_load_control, .test_run, .test_transfer,
  .utility_avail, .system_fault, .fault_indicator,
  .generator_supply_indicator, .remote_horn,
  .local_horn, .alarm_silenced);

/* verification/obc_panel.sv */
// Remote alarm panel model: test contact and silence button
`timescale 1ns/1ps
module obc_panel (
  input  wire logic mclk,
  output logic      remote_test_in,
  output logic      silence_btn
);
  // Both contacts open at power up
  initial begin
    remote_test_in = 1'b0;
    silence_btn    = 1'b0;
  end
  // Maintained contact level, changed just after an edge
  task set_test(input logic v);
    @(posedge mclk);
    remote_test_in <= v;
  endtask : set_test
  // Press held for a number of cycles, then released
  task press(input logic btn, input int cyc);
    @(posedge mclk);
    if (btn) silence_btn <= 1'b1;
    else remote_test_in <= 1'b1;
    repeat (cyc) @(posedge mclk);
    silence_btn    <= 1'b0;
    remote_test_in <= 1'b0;
  endtask : press
endmodule : obc_panel

/* verification/test_obc_ctrl.sv */
// Testbench for the option-board controller
`timescale 1ns/1ps
`include "obc_defs.svh"
module test_obc_ctrl;
  localparam int TK = 4;  // Cycles per tick
  localparam int ST = 10; // Ticks for a switch to settle
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, er, exercise_done;
  logic        utility_avail, gen_running, load_on_gen, silent_mode, system_fault, panel_batt_low;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sel_cooldown, sel_start, sel_xfer, sel_retransfer, sel_exercise;
  logic [4:0]  cfg_sw;
  logic [15:0] dly_engine_start, dly_xfer_to_emerg, dly_retransfer, dly_cooldown, dly_exercise_run, dly_load_control;
  logic        exercise_two_week, exercise_loaded, test_run, test_transfer, generator_supply_indicator;
  logic        fault_indicator, remote_horn, local_horn, alarm_silenced, remote_test_in, silence_btn;
  logic [3:0]  pos [4];
  int          err_count, tests_run, hi, rs;
  wire  [3:0]  obs = {local_horn, remote_horn, fault_indicator, generator_supply_indicator};

  obc_ctrl #(.TICK_CYCLES(TK)) u_obc_ctrl (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sel_cooldown, .sel_start, .sel_xfer, .sel_retransfer, .sel_exercise, .cfg_sw, .remote_test_in,
    .silence_btn, .utility_avail, .gen_running, .load_on_gen, .silent_mode, .system_fault, .panel_batt_low,
    .exercise_done, .dly_engine_start, .dly_xfer_to_emerg, .dly_retransfer, .dly_cooldown, .dly_exercise_run,
    .dly_load_control, .exercise_two_week, .exercise_loaded, .test_run, .test_transfer,
    .generator_supply_indicator, .fault_indicator, .remote_horn, .local_horn, .alarm_silenced);
  obc_panel u_obc_panel (.mclk(mclk), .remote_test_in(remote_test_in), .silence_btn(silence_btn));

  // ==========================================
  // Helpers
  function automatic int dec(input logic [3:0] p);
    return (p == 4'h0) ? 10 : int'(p);
  endfunction : dec
  task tk(input int n);
    repeat (n * TK) @(posedge mclk);
  endtask : tk
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Counts high cycles and rising edges of one panel output over n cycles
  task watch(input int k, input int n);
    logic p;
    @(posedge mclk);
    p  = obs[k];
    hi = 0;
    rs = 0;
    repeat (n) begin
      @(posedge mclk);
      hi += int'(obs[k] === 1'b1);
      rs += int'(obs[k] === 1'b1 && p === 1'b0);
      p = obs[k];
    end
  endtask : watch
  task results();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // ==========================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    results();
  end

  // ==========================================
  // Test sequence
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, exercise_done} = {1'b1, 48'h0};
    {gen_running, load_on_gen, silent_mode, system_fault, panel_batt_low} = 5'h00;
    {sel_cooldown, sel_start, sel_xfer, sel_retransfer, sel_exercise} = 20'h0;
    utility_avail = 1'b1;
    cfg_sw        = 5'h00;
    pos           = '{4'h0, 4'h1, 4'h5, 4'h9};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, `OBC_REG_CTRL, 32'h0);
    chk("ctrl reset", rd, `OBC_CTRL_RESET);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `OBC_REG_CTRL, 32'hffff_fffc);
    apb(1'b0, `OBC_REG_CTRL, 32'h0);
    chk("ctrl bits", rd, 32'h0);
    apb(1'b1, `OBC_REG_CTRL, 32'h3);
    // Selector decode, start and exercise selectors on one position, the others each on a different one
    for (int i = 0; i < 4; i++) begin
      sel_cooldown   <= pos[i];
      sel_start      <= pos[(i + 1) % 4];
      sel_xfer       <= pos[(i + 2) % 4];
      sel_retransfer <= pos[(i + 3) % 4];
      sel_exercise   <= pos[(i + 1) % 4];
      cfg_sw         <= {1'b0, i[0], 3'h0};
      tk(ST);
      chk("start", 32'(dly_engine_start), dec(pos[(i + 1) % 4]) * 10);
      chk("xfer", 32'(dly_xfer_to_emerg), dec(pos[(i + 2) % 4]) * 10);
      chk("retr", 32'(dly_retransfer), dec(pos[(i + 3) % 4]) * 1800);
      chk("cool", 32'(dly_cooldown), dec(pos[i]) * 600);
      chk("exer", 32'(dly_exercise_run), dec(pos[(i + 1) % 4]) * 3000);
      chk("loadctl", 32'(dly_load_control), i[0] ? 6000 : 3000);
    end
    // Factory positions with the board unused
    apb(1'b1, `OBC_REG_CTRL, 32'h2);
    tk(1);
    chk("fac", {dly_engine_start, dly_retransfer}, {16'h001e, 16'h2328});
    chk("fac2", {dly_cooldown, dly_exercise_run}, {16'h0bb8, 16'h2ee0});
    apb(1'b1, `OBC_REG_CTRL, 32'h3);
    // Exercise interval and loading
    cfg_sw <= 5'h07;
    tk(ST);
    chk("first loaded", 32'(exercise_loaded), 32'h0);
    chk("two week", 32'(exercise_two_week), 32'h1);
    exercise_done <= 1'b1;
    @(posedge mclk);
    exercise_done <= 1'b0;
    cfg_sw        <= 5'h06;
    tk(ST);
    chk("later loaded", 32'(exercise_loaded), 32'h1);
    chk("two week held", 32'(exercise_two_week), 32'h1);
    exercise_done <= 1'b1;
    @(posedge mclk);
    exercise_done <= 1'b0;
    tk(1);
    chk("one week", 32'(exercise_two_week), 32'h0);
    // Maintained remote test start, run and stop
    u_obc_panel.set_test(1'b1);
    tk(ST);
    chk("test run", 32'(test_run), 32'h1);
    apb(1'b0, `OBC_REG_STATUS, 32'h0);
    chk("starting", 32'(rd[1:0]), 32'h1);
    watch(0, 40 * TK);
    chk("slow flash", rs, 2);
    gen_running <= 1'b1;
    load_on_gen <= 1'b1;
    watch(2, 20 * TK);
    chk("run chirp", rs, 1);
    watch(0, 40 * TK);
    chk("steady", hi, 40 * TK);
    utility_avail <= 1'b0;
    u_obc_panel.set_test(1'b0);
    tk(ST);
    chk("no stop", 32'(test_run), 32'h1);
    utility_avail <= 1'b1;
    u_obc_panel.set_test(1'b1);
    tk(ST);
    u_obc_panel.set_test(1'b0);
    tk(ST);
    chk("stopped", 32'(test_run), 32'h0);
    watch(0, 40 * TK);
    chk("stop flash", rs, 2);
    gen_running <= 1'b0;
    tk(ST);
    gen_running <= 1'b1;
    watch(2, 40 * TK);
    chk("auto no chirp", rs, 0);
    silent_mode <= 1'b1;
    watch(0, 40 * TK);
    chk("fast flash", rs, 4);
    {gen_running, load_on_gen, silent_mode} <= 3'h0;
    // Momentary test: short press, refused input, real presses
    cfg_sw <= 5'h03;
    tk(ST);
    u_obc_panel.press(1'b0, 5 * TK);
    tk(ST);
    chk("short press", 32'(test_run), 32'h0);
    apb(1'b1, `OBC_REG_CTRL, 32'h1);
    u_obc_panel.press(1'b0, 14 * TK);
    tk(ST);
    chk("test disabled", 32'(test_run), 32'h0);
    apb(1'b1, `OBC_REG_CTRL, 32'h3);
    u_obc_panel.press(1'b0, 14 * TK);
    tk(1220);
    chk("mom start", 32'(test_run), 32'h1);
    watch(1, 40 * TK);
    chk("start fail", rs, 2);
    u_obc_panel.press(1'b0, 14 * TK);
    tk(ST);
    chk("mom stop", 32'(test_run), 32'h0);
    // Faults, horns and silence
    panel_batt_low <= 1'b1;
    tk(ST);
    chk("batt fault", 32'(fault_indicator), 32'h1);
    panel_batt_low <= 1'b0;
    cfg_sw         <= 5'h13;
    tk(ST);
    system_fault <= 1'b1;
    watch(2, 30 * TK);
    chk("three chirps", rs, 3);
    watch(1, 40 * TK);
    chk("fault steady", hi, 40 * TK);
    chk("local horn", 32'(local_horn), 32'h1);
    cfg_sw <= 5'h03;
    tk(ST);
    chk("horn off", 32'(local_horn), 32'h0);
    cfg_sw <= 5'h13;
    u_obc_panel.press(1'b1, 6 * TK);
    tk(ST);
    chk("silenced", 32'(alarm_silenced), 32'h1);
    chk("muted", 32'(local_horn), 32'h0);
    u_obc_panel.press(1'b1, 6 * TK);
    tk(ST);
    chk("unsilenced", 32'(alarm_silenced), 32'h0);
    chk("horn back", 32'(local_horn), 32'h1);
    system_fault <= 1'b0;
    tk(2);
    results();
  end
endmodule : test_obc_ctrl
